// ### design/i2c_bit_timing_divider.sv
// bit-timing core: divisor lookup, filtered bus events, slave stretch delay
// assumes i_scl/i_sda are synchronous pin levels and the controller drives
// divider_select and filter_sample_rate as steady levels
`default_nettype none
// Summary of operation
// (RULE_01) scl and sda are judged only after the sampling filter
// (RULE_02) all counts are clock cycles, applied after the filter delay
// (RULE_03) a start is recognised only after four qualified cycles of hold
// (RULE_04) slave waits 8 + 16*2^exp*(5-k) cycles before pulling scl low
// (RULE_05) scl high shorter than five cycles yields no data bit
// (RULE_06) repeated start needs four cycles of setup before it
// (RULE_07) stop needs four cycles of setup before it
// (RULE_08) low codes give paired divisors doubling every four codes
// (RULE_09) upper codes give the short head then doubling groups
// (RULE_10) each code sets the bit clock rate of its divisor; several codes share a rate
// (RULE_11) all six divider bits index the divisor lookup
// (RULE_12) k for bits 5,1: 10 gives 4, 11 gives 3, 00 gives 2, 01 gives 1
// (RULE_13) a zero sample rate gives the shortest filter delay
module i2c_bit_timing_divider
  import i2c_timing_pkg::*;
#(
  parameter int unsigned            RATE_W      = FSR_W,
  parameter logic [STRETCH_W-1:0]   STRETCH_B   = STRETCH_BASE[STRETCH_W-1:0],
  parameter logic [STRETCH_W-1:0]   STRETCH_U   = STRETCH_UNIT[STRETCH_W-1:0]
)(
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic [DIV_SEL_W-1:0]         i_divider_select,
  input  wire logic [RATE_W-1:0]            i_filter_sample_rate,
  input  wire i2c_timing_pkg::bus_pair_t    i_bus,
  input  wire logic                         i_gen_enable,
  input  wire logic                         i_slave_tx,
  input  wire logic                         i_stretch_req,
  output var  i2c_timing_pkg::bus_pair_t    o_qual,
  output var  i2c_timing_pkg::bus_event_t   o_event,
  output logic [DIVISOR_W-1:0]              o_divisor,
  output logic                              o_bit_clk,
  output logic                              o_scl_o,
  output logic                              o_scl_oe
);
  import i2c_timing_pkg::*;

  // (RULE_08) (RULE_09) divisor for any code
  function automatic logic [DIVISOR_W-1:0] divisor_of(input logic [DIV_SEL_W-1:0] code);
    logic [DIV_SEL_W-1:0] rel;
    rel = code - UPPER_REPEAT[DIV_SEL_W-1:0];
    if (code == TOP_LOW_CODE[DIV_SEL_W-1:0]) divisor_of = TOP_LOW_DIV;
    else if (code < UPPER_CODE[DIV_SEL_W-1:0]) divisor_of = LOW_GRP[code[1:0]] << code[4:2];
    else if (code < UPPER_REPEAT[DIV_SEL_W-1:0]) divisor_of = UP_HEAD[code[2:0]];
    else divisor_of = UP_GRP[rel[1:0]] << rel[4:2];
  endfunction : divisor_of

  // (RULE_12) subtraction term from bits 5 and 1
  function automatic logic [2:0] k_of(input logic [DIV_SEL_W-1:0] code);
    case ({code[DIV_HI_BIT], code[DIV_LO_BIT]})
      2'b10:   k_of = 3'h4;
      2'b11:   k_of = 3'h3;
      2'b00:   k_of = 3'h2;
      default: k_of = 3'h1;
    endcase
  endfunction : k_of

  bus_pair_t               q;
  bus_pair_t               prev_q;
  logic [STATE_CNT_W-1:0]  cnt_q;
  logic [STATE_CNT_W-1:0]  high_q;
  logic                    start_pend_q;
  bus_event_t              ev_q;
  logic [DIVISOR_W-1:0]    div_q;
  logic [DIVISOR_W-1:0]    bclk_cnt_q;
  logic                    bclk_q;
  logic [STRETCH_W-1:0]    str_cnt_q;
  logic                    str_run_q;
  logic                    oe_q;

  // (RULE_01) qualification filter
  i2c_sample_filter #(.RATE_W(RATE_W)) u_filter (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_rate (i_filter_sample_rate),
    .i_raw  (i_bus),
    .o_qual (q)
  );

  // edge and condition decode on qualified levels
  wire changed   = (q != prev_q);
  wire old_len4  = (cnt_q >= STATE_CNT_W'(SETUP_CLKS - 1));
  wire sda_fall  = prev_q.scl && q.scl && prev_q.sda && !q.sda;
  wire sda_rise  = prev_q.scl && q.scl && !prev_q.sda && q.sda;
  wire scl_fall  = prev_q.scl && !q.scl;
  wire start_now = start_pend_q && (q == bus_pair_t'{scl: 1'b1, sda: 1'b0})
                   && (cnt_q == STATE_CNT_W'(START_HOLD_CLKS - 1));
  wire bit_ok    = scl_fall && (high_q >= STATE_CNT_W'(HIGH_MIN_CLKS));
  wire [2:0]             k_term   = 3'(STRETCH_TERMS) - k_of(i_divider_select);
  wire [STRETCH_W-1:0]   str_load = STRETCH_B
                                    + STRETCH_W'((STRETCH_U << i_divider_select[DIV_EXP_MSB:DIV_EXP_LSB]) * k_term);

  // cycle counters for the current pair and for scl high; saturate at the top
  always_ff @(posedge i_clk)
    if (!i_nrst)
    begin
      prev_q <= '{scl: 1'b1, sda: 1'b1};
      cnt_q  <= '0;
      high_q <= '0;
    end
    else
    begin
      prev_q <= q;
      // (RULE_02) counts start from qualified change
      cnt_q  <= changed ? '0 : (&cnt_q ? cnt_q : cnt_q + 1'b1);
      high_q <= !q.scl ? '0 : (&high_q ? high_q : high_q + 1'b1);
    end

  // start, stop and bit events
  always_ff @(posedge i_clk)
    if (!i_nrst)
    begin
      start_pend_q <= 1'b0;
      ev_q         <= '0;
    end
    else
    begin
      // (RULE_06) setup before start
      if (sda_fall) start_pend_q <= old_len4;
      else if (changed || start_now) start_pend_q <= 1'b0;
      // (RULE_03) start hold qualified
      ev_q.start     <= start_now;
      // (RULE_07) stop setup qualified
      ev_q.stop      <= sda_rise && old_len4;
      // (RULE_05) minimum high period
      ev_q.bit_valid <= bit_ok;
      ev_q.bit_data  <= bit_ok ? prev_q.sda : ev_q.bit_data;
    end

  // (RULE_11) (RULE_10) bit clock from the selected divisor, half period per phase
  always_ff @(posedge i_clk)
    if (!i_nrst)
    begin
      div_q      <= '0;
      bclk_cnt_q <= '0;
      bclk_q     <= 1'b1;
    end
    else
    begin
      div_q <= divisor_of(i_divider_select);
      if (!i_gen_enable)
      begin
        bclk_cnt_q <= '0;
        bclk_q     <= 1'b1;
      end
      else if (bclk_cnt_q >= (div_q >> 1) - 1'b1)
      begin
        bclk_cnt_q <= '0;
        bclk_q     <= !bclk_q;
      end
      else bclk_cnt_q <= bclk_cnt_q + 1'b1;
    end

  // (RULE_04) stretch wait then hold scl low while requested
  always_ff @(posedge i_clk)
    if (!i_nrst)
    begin
      str_cnt_q <= '0;
      str_run_q <= 1'b0;
      oe_q      <= 1'b0;
    end
    else if (!i_slave_tx || !i_stretch_req)
    begin
      str_cnt_q <= '0;
      str_run_q <= 1'b0;
      oe_q      <= 1'b0;
    end
    else if (scl_fall && !oe_q)
    begin
      str_cnt_q <= str_load - 1'b1; // wait runs from the qualified fall
      str_run_q <= 1'b1;
    end
    else if (str_run_q)
    begin
      str_cnt_q <= str_cnt_q - 1'b1;
      if (str_cnt_q == '0)
      begin
        str_run_q <= 1'b0;
        oe_q      <= 1'b1;
      end
    end

  assign o_qual    = q;
  assign o_event   = ev_q;
  assign o_divisor = div_q;
  assign o_bit_clk = bclk_q;
  assign o_scl_o   = 1'b0; // open drain: only ever pulls low
  assign o_scl_oe  = oe_q;

  // checks
  logic [STRETCH_W-1:0] wait_len_q;
  always_ff @(posedge i_clk)
    if (!i_nrst || !str_run_q) wait_len_q <= '0;
    else wait_len_q <= wait_len_q + 1'b1;

  AST_DIV_LOW: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_08
    $stable(i_divider_select) && i_divider_select == 6'h1F |=> o_divisor == 16'hF000)
    else $error("divisor for top low code wrong");
  AST_DIV_HIGH: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_09
    $stable(i_divider_select) && i_divider_select == 6'h3E |=> o_divisor == 16'h7800)
    else $error("divisor for code 3e wrong");
  AST_DIV_HEAD: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
    $stable(i_divider_select) && i_divider_select == 6'h20 |=> o_divisor == 16'h00A0)
    else $error("divisor for code 20 wrong");
  AST_BCLK_HALF: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_10
    i_gen_enable && $stable(o_divisor) && bclk_cnt_q > (o_divisor >> 1) |-> 1'b0)
    else $error("bit clock phase overran half divisor");
  AST_START_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_03
    o_event.start |-> $past(prev_q.scl, 1) && !$past(prev_q.sda, 1) && cnt_q >= 3'h3)
    else $error("start reported without hold");
  AST_STOP_SETUP: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_07
    sda_rise && cnt_q < 3'h3 |=> !o_event.stop)
    else $error("stop reported with short setup");
  AST_RSTART_SETUP: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_06
    sda_fall && cnt_q < 3'h3 |=> !start_pend_q)
    else $error("start armed with short setup");
  AST_HIGH_MIN: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_05
    scl_fall && high_q < 3'h5 |=> !o_event.bit_valid)
    else $error("bit taken from short high period");
  AST_STRETCH_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_04
    $rose(o_scl_oe) |-> wait_len_q == str_load && $past(str_run_q, 1))
    else $error("stretch started without wait");
  AST_STRETCH_EARLY: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_04
    scl_fall && i_slave_tx && i_stretch_req && !o_scl_oe |=> !o_scl_oe [*8])
    else $error("scl pulled low before base delay");
  AST_FILTER_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_13
    i_filter_sample_rate == '0 && $past(i_filter_sample_rate == '0) |-> o_qual == $past(i_bus))
    else $error("zero rate filter delay wrong");
  AST_QUAL_DELAY: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_01
    $changed(o_qual) && i_filter_sample_rate != '0 |-> $past(i_filter_sample_rate != '0))
    else $error("qualified level moved without filtering");

  COV_START: cover property (@(posedge i_clk) disable iff (!i_nrst) o_event.start);
  COV_STOP:  cover property (@(posedge i_clk) disable iff (!i_nrst) o_event.stop);
  COV_BIT:   cover property (@(posedge i_clk) disable iff (!i_nrst) o_event.bit_valid);
  COV_STR:   cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_scl_oe));
endmodule : i2c_bit_timing_divider
`default_nettype wire

// ### design/i2c_timing_pkg.sv
// package for the i2c bit-timing block: cycle counts, field layout, carriers
// assumes every count is in cycles of the single memory bus clock
`default_nettype none
package i2c_timing_pkg;
  // divider_select field layout
  localparam int unsigned DIV_SEL_W      = 6;
  localparam int unsigned DIV_HI_BIT     = 5;
  localparam int unsigned DIV_LO_BIT     = 1;
  localparam int unsigned DIV_EXP_MSB    = 4;
  localparam int unsigned DIV_EXP_LSB    = 2;
  localparam int unsigned DIVISOR_W      = 16;
  localparam int unsigned FSR_W          = 6;
  // qualified-signal timing, counted in clock cycles
  localparam int unsigned START_HOLD_CLKS = 4;
  localparam int unsigned HIGH_MIN_CLKS   = 5;
  localparam int unsigned SETUP_CLKS      = 4;
  localparam int unsigned FILTER_MULT     = 2;
  localparam int unsigned STATE_CNT_W     = 3;
  // slave stretch delay: base + unit * 2^exp * (terms - k)
  localparam int unsigned STRETCH_BASE   = 8;
  localparam int unsigned STRETCH_UNIT   = 16;
  localparam int unsigned STRETCH_TERMS  = 5;
  localparam int unsigned STRETCH_W      = 14;
  // divisor tables: low half base group, upper half head and repeating group
  localparam int unsigned UPPER_CODE     = 'h20;
  localparam int unsigned UPPER_REPEAT   = 'h26;
  // the last low code breaks the doubling pattern and has its own divisor
  localparam int unsigned TOP_LOW_CODE   = 'h1F;
  localparam logic [15:0] TOP_LOW_DIV    = 16'hF000;
  localparam logic [15:0] LOW_GRP [4]  = '{16'h0120, 16'h0140, 16'h0180, 16'h01C0};
  localparam logic [15:0] UP_HEAD [6]  = '{16'h00A0, 16'h00C0, 16'h00E0, 16'h0100, 16'h0140, 16'h0180};
  localparam logic [15:0] UP_GRP  [4]  = '{16'h01E0, 16'h0200, 16'h0280, 16'h0300};

  // scl/sda travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pair_t;

  // qualified bus events, one-cycle pulses except bit_data, which holds the last bit
  typedef struct packed {
    logic start;
    logic stop;
    logic bit_valid;
    logic bit_data;
  } bus_event_t;
endpackage : i2c_timing_pkg
`default_nettype wire

// ### design/i2c_sample_filter.sv
// qualification filter for scl and sda
// assumes raw pins are already synchronous to i_clk
`default_nettype none
module i2c_sample_filter
  import i2c_timing_pkg::*;
#(
  parameter int unsigned RATE_W = FSR_W
)(
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic [RATE_W-1:0]           i_rate,
  input  wire i2c_timing_pkg::bus_pair_t   i_raw,
  output var  i2c_timing_pkg::bus_pair_t   o_qual
);
  import i2c_timing_pkg::*;

  bus_pair_t         cand_q;
  bus_pair_t         qual_q;
  logic [RATE_W:0]   run_q;
  // a new pair must stand two sample periods per rate step before it counts
  wire [RATE_W:0]    need  = (RATE_W+1)'(FILTER_MULT * i_rate);
  wire               moved = (i_raw != cand_q);
  wire               held  = (run_q >= need - 1'b1);

  // (RULE_01) fixed lag of rate*2+1 cycles, so every edge moves by the same amount
  always_ff @(posedge i_clk)
    if (!i_nrst)
    begin
      cand_q <= '{scl: 1'b1, sda: 1'b1};
      run_q  <= '0;
      qual_q <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      if (moved)
      begin
        cand_q <= i_raw;
        run_q  <= '0;
      end
      else if (!(&run_q)) run_q <= run_q + 1'b1;
      // (RULE_13) zero rate: one-cycle path
      if (i_rate == '0) qual_q <= i_raw;
      else if (!moved && held) qual_q <= cand_q; // pulses shorter than the lag never reach qual
    end

  assign o_qual = qual_q;
endmodule : i2c_sample_filter
`default_nettype wire

// ### tb/i2c_far_model.sv
// far-side bus master model: drives open-drain scl and sda levels
// assumes the bench ands scl with the device pull-down; released lines read 1
`default_nettype none
module i2c_far_model
  import i2c_timing_pkg::*;
(
  input  wire logic                      i_clk,
  output var  i2c_timing_pkg::bus_pair_t o_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // pull-ups hold the idle bus high
  initial o_line = 2'b11;

  // one level pair, changed just after an edge, then held n cycles
  task automatic put(input logic scl, input logic sda, input int n);
    @(posedge i_clk);
    #1 o_line = {scl, sda};
    repeat (n) @(posedge i_clk);
    #1; // callers resume off the edge
  endtask : put

  task automatic start(input int h);
    put(o_line.scl, 1'b1, h);
    put(1'b1, 1'b1, h);
    put(1'b1, 1'b0, h);
    put(1'b0, 1'b0, h);
  endtask : start

  task automatic bit_cycle(input logic d, input int hi, input int h);
    put(1'b0, d, h);
    put(1'b1, d, hi);
    put(1'b0, d, h);
  endtask : bit_cycle

  task automatic stop(input int h);
    put(1'b0, 1'b0, h);
    put(1'b1, 1'b0, h);
    put(1'b1, 1'b1, h);
  endtask : stop
endmodule : i2c_far_model
`default_nettype wire

// ### tb/i2c_bit_timing_divider_tb_top.sv
// top bench: divisor lookup, bit clock, filter lag, bus events, slave stretch
// assumes the far model owns the bus and the device only pulls scl low
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module i2c_bit_timing_divider_tb_top
  import i2c_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 i_clk;
  logic                 i_nrst;
  logic [DIV_SEL_W-1:0] code;
  logic [FSR_W-1:0]     rate;
  logic                 gen_en;
  logic                 slv;
  logic                 sreq;
  logic                 lvl;
  bus_pair_t            line;
  bus_pair_t            bus_w;
  bus_pair_t            o_qual;
  bus_event_t           o_event;
  logic [DIVISOR_W-1:0] o_divisor;
  logic                 o_bit_clk;
  logic                 o_scl_o;
  logic                 o_scl_oe;
  logic [4:0]           exp_q[$];
  logic [4:0]           note;
  int                   num_errors = 0;
  int                   n_tests    = 0;
  int                   seed       = 32'h4403608e;
  int                   cyc        = 0;
  int                   c;
  int                   r;
  int                   e;
  int                   k;

  // wired-and scl: the device pull-down wins over the model
  assign bus_w = {line.scl & ~o_scl_oe, line.sda};

  i2c_far_model far (.i_clk(i_clk), .o_line(line));

  // short stretch unit keeps the slave wait within 520 cycles
  i2c_bit_timing_divider #(.STRETCH_U(14'h0001)) uut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_divider_select(code), .i_filter_sample_rate(rate),
    .i_bus(bus_w), .i_gen_enable(gen_en), .i_slave_tx(slv), .i_stretch_req(sreq),
    .o_qual(o_qual), .o_event(o_event), .o_divisor(o_divisor), .o_bit_clk(o_bit_clk),
    .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe));

  // divisor from the pairing and doubling pattern of the lookup
  function automatic logic [15:0] exp_div(input logic [5:0] s);
    int lo[4] = '{288, 320, 384, 448};
    int hd[6] = '{160, 192, 224, 256, 320, 384};
    int gp[4] = '{480, 512, 640, 768};
    int n;
    n = int'(s) - 'h26;
    if (s == 6'h1F) return 16'(61440);
    if (!s[5]) return 16'(lo[s[1:0]] << s[4:2]);
    if (n < 0) return 16'(hd[s - 6'h20]);
    return 16'(gp[n % 4] << (n / 4));
  endfunction : exp_div

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // count edges until the watched level leaves lvl, bounded
  task automatic wait_change(input int lim, input int sel);
    c = 0;
    while ((sel == 0 ? o_qual.scl : sel == 1 ? o_bit_clk : ~o_scl_oe) === lvl && c < lim)
    begin
      @(posedge i_clk);
      #1 c++;
    end
  endtask : wait_change

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // hang guard, well above the few thousand cycles of the run
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // event pulses take the oldest note; optional notes absorb a possible bit
  always @(negedge i_clk)
  begin
    if (i_nrst && (o_event.start || o_event.stop || o_event.bit_valid))
    begin
      if (exp_q.size() > 0 && exp_q[0][4] && !o_event.bit_valid) void'(exp_q.pop_front());
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h0e;
      if (!note[4]) `CHK("event_kind", note[3:1], {o_event.start, o_event.stop, o_event.bit_valid})
      if (!note[4] && note[1]) `CHK("bit_data", note[0], o_event.bit_data)
    end
  end

  initial
  begin
    i_nrst = 1'b0;
    code   = '0;
    rate   = '0;
    gen_en = 1'b0;
    slv    = 1'b0;
    sreq   = 1'b0;
    repeat (6) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    @(posedge i_clk);
    #1 `CHK("qual_reset", 2'b11, o_qual)
    `CHK("stretch_off", 1'b0, o_scl_oe)
    `CHK("scl_level", 1'b0, o_scl_o)
    `CHK("bitclk_idle", 1'b1, o_bit_clk)
    for (int i = 0; i < 64; i++)
    begin
      code = 6'(i);
      repeat (2) @(posedge i_clk);
      #1 `CHK("divisor", exp_div(code), o_divisor)
    end
    // two codes of one input limit, distinct bit clocks
    gen_en = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      code = 6'h20 + 6'(i);
      repeat (4) @(posedge i_clk);
      #1;
      for (int j = 0; j < 2; j++)
      begin
        lvl = o_bit_clk;
        wait_change(500, 1);
      end
      `CHK("half_period", exp_div(code) / 2, 16'(c))
    end
    gen_en = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 `CHK("bitclk_off", 1'b1, o_bit_clk)
    // filter lag, then framed traffic, at zero and at a random rate
    for (int i = 0; i < 2; i++)
    begin
      r = (i == 0) ? 0 : 1 + ($unsigned($random(seed)) % 3);
      rate = 6'(r);
      far.put(1'b1, 1'b1, 20);
      exp_q.push_back(5'b1_0010);
      far.put(1'b0, 1'b1, 0);
      lvl = 1'b1;
      wait_change(40, 0);
      `CHK("qual_lag", 2 * r + 1, c)
      far.put(1'b1, 1'b1, 20);
      for (int j = 0; j < 2; j++)
      begin
        exp_q.push_back(5'b0_1000);
        exp_q.push_back(5'b1_0010);
        far.start(16);
        lvl = 1'($random(seed));
        exp_q.push_back({4'b0001, lvl});
        far.bit_cycle(lvl, 16, 16);
        far.bit_cycle(1'b1, 3, 16); // high too short, no bit expected
      end
      exp_q.push_back(5'b0_0100);
      far.stop(16);
    end
    // stretch wait for every {bit5,bit1} pair
    rate = '0;
    // three-cycle holds are refused, then a clean stop
    far.put(1'b1, 1'b0, 2);
    far.put(1'b1, 1'b1, 2);
    far.put(1'b1, 1'b0, 16);
    exp_q.push_back(5'b0_0100);
    far.put(1'b1, 1'b1, 20);
    slv  = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      e = $unsigned($random(seed)) % 8;
      code = {i[1], 3'(e), i[0], 1'($random(seed))};
      k = (i == 2) ? 4 : (i == 3) ? 3 : (i == 0) ? 2 : 1;
      sreq = 1'b1;
      exp_q.push_back(5'b1_0010);
      far.put(1'b0, 1'b1, 0);
      lvl = 1'b1;
      wait_change(700, 2);
      k = 8 + (1 << e) * (5 - k) + 2;
      `CHK("stretch_wait", k, c)
      // dropping either qualifier must release scl
      if ($random(seed) & 1) sreq = 1'b0;
      else slv = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 `CHK("stretch_abort", 1'b0, o_scl_oe)
      slv = 1'b1;
      far.put(1'b1, 1'b1, 20);
    end
    repeat (40) @(posedge i_clk);
    while (exp_q.size() > 0 && exp_q[0][4]) void'(exp_q.pop_front());
    `CHK("notes_left", 0, exp_q.size())
    print_verdict();
  end
endmodule : i2c_bit_timing_divider_tb_top
`default_nettype wire
